// ===== design/spsmc_pkg.sv
// Package for the serial port status and modem control block.
package spsmc_pkg;
	// ==========================================================
	// Protocol modes
	typedef enum logic [2:0]
	{
		SPSMC_RAW = 3'h0,
		SPSMC_FRAMED = 3'h1,
		SPSMC_ACKED = 3'h2,
		SPSMC_DRIVE = 3'h3,
		SPSMC_MB_MASTER = 3'h4,
		SPSMC_MB_SLAVE = 3'h5
	} spsmc_mode_t;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] SPSMC_A_CTRL = 4'h0;
	localparam logic [3:0] SPSMC_A_SEND = 4'h1;
	localparam logic [3:0] SPSMC_A_EVENT = 4'h2;
	localparam logic [3:0] SPSMC_A_RESULT = 4'h3;
	localparam logic [3:0] SPSMC_A_RXLEN = 4'h4;
	localparam logic [3:0] SPSMC_A_RXERR = 4'h5;
	localparam logic [3:0] SPSMC_A_MODEM = 4'h6;
	localparam logic [3:0] SPSMC_A_MSTAT = 4'h7;
	localparam logic [3:0] SPSMC_A_MBFC = 4'h8;

	// ==========================================================
	// Field positions
	localparam int SPSMC_CTRL_MODE = 0;
	localparam int SPSMC_CTRL_HS = 4;
	localparam int SPSMC_CTRL_CFG = 6;
	localparam int SPSMC_CTRL_PRESENT = 7;
	localparam int SPSMC_MW_DTR = 0;
	localparam int SPSMC_MW_RTS = 1;
	localparam int SPSMC_MW_MASK = 8;
	localparam int SPSMC_RXE_OVR = 1;
	localparam int SPSMC_RXE_PAR = 2;
	localparam int SPSMC_RXE_FRM = 3;
	localparam int SPSMC_SEND_BAD = 9;
	localparam int SPSMC_SEND_FULL = 10;

	// ==========================================================
	// Result codes
	localparam logic [15:0] SPSMC_RC_DONE = 16'h0000;
	localparam logic [15:0] SPSMC_RC_EMPTY = 16'h1000;
	localparam logic [15:0] SPSMC_RC_BUFFERED = 16'h7001;
	localparam logic [15:0] SPSMC_RC_ACTIVE = 16'h7002;
	localparam logic [15:0] SPSMC_RC_OK = 16'h2000;
	localparam logic [15:0] SPSMC_RC_OK_ERR = 16'h2001;
	localparam logic [15:0] SPSMC_RC_NO_IF = 16'h809A;
	localparam logic [15:0] SPSMC_RC_NO_CFG = 16'h809B;
	localparam logic [15:0] SPSMC_RC_OVFL = 16'h9000;
	localparam logic [15:0] SPSMC_RC_LONG = 16'h9001;
	localparam logic [15:0] SPSMC_RC_SHORT = 16'h9002;
	localparam logic [15:0] SPSMC_RC_BADCH = 16'h9004;
	localparam logic [15:0] SPSMC_RC_NAK = 16'h80FF;
	localparam logic [15:0] SPSMC_RC_NOACK = 16'h80FE;
	localparam logic [15:0] SPSMC_RC_NOSPACE = 16'h8080;
	localparam logic [15:0] SPSMC_RC_TMO = 16'h8090;
	localparam logic [15:0] SPSMC_RC_CSUM = 16'h80F0;
	localparam logic [15:0] SPSMC_RC_RLONG = 16'h80FD;
	localparam logic [7:0] SPSMC_HI_OK = 8'h20;
	localparam logic [7:0] SPSMC_HI_ERR = 8'h80;
	localparam logic [7:0] SPSMC_HI_NOEX = 8'h90;
	localparam logic [7:0] SPSMC_FC_ERR = 8'h80;
	localparam logic [8:0] SPSMC_MAX_LEN = 9'h100;
	localparam logic [8:0] SPSMC_MIN2 = 9'h002;

	// ==========================================================
	// Event codes posted by the engine
	localparam logic [3:0] SPSMC_EV_NONE = 4'h0;
	localparam logic [3:0] SPSMC_EV_BUF = 4'h1;
	localparam logic [3:0] SPSMC_EV_LINE = 4'h2;
	localparam logic [3:0] SPSMC_EV_DONE = 4'h3;
	localparam logic [3:0] SPSMC_EV_NAK = 4'h4;
	localparam logic [3:0] SPSMC_EV_NOACK = 4'h5;
	localparam logic [3:0] SPSMC_EV_NOSPACE = 4'h6;
	localparam logic [3:0] SPSMC_EV_TMO = 4'h7;
	localparam logic [3:0] SPSMC_EV_CSUM = 4'h8;
	localparam logic [3:0] SPSMC_EV_RLONG = 4'h9;
	localparam logic [3:0] SPSMC_EV_BADFC = 4'hA;
	localparam logic [3:0] SPSMC_EV_ADDR = 4'hB;
	localparam logic [3:0] SPSMC_EV_DIAG_OK = 4'hC;
	localparam logic [3:0] SPSMC_EV_DIAG_ERR = 4'hD;
	localparam logic [3:0] SPSMC_EV_DIAG_NOEX = 4'hE;
	localparam logic [3:0] SPSMC_EV_OK_ERR = 4'hF;

	// Bus request carrier.
	typedef struct packed
	{
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} spsmc_bus_t;

	// Modem input lines.
	typedef struct packed
	{
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} spsmc_lines_t;
endpackage

// ===== design/spsmc_top.sv
// Status, result code and modem line logic of a serial port.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
module spsmc_top
(
	input wire logic mclk,
	input wire logic resetn,
	input wire spsmc_pkg::spsmc_bus_t bus,
	output logic [15:0] rdata,
	input wire logic [3:0] ev_code,
	input wire logic [7:0] ev_diag,
	input wire logic [8:0] rx_count,
	input wire logic rx_user_ok,
	input wire logic rx_area_small,
	input wire logic [2:0] rx_line_err,
	input wire spsmc_pkg::spsmc_lines_t lines_in,
	input wire logic [7:0] mb_fc,
	input wire logic mb_fail,
	input wire logic mb_fc_valid,
	output logic dtr,
	output logic rts,
	output logic send_go,
	output logic [8:0] send_len,
	output logic [1:0] mb_area
);
	import spsmc_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] ctrl_q;
	logic [15:0] result_q, result_d;
	logic [8:0] rxlen_q;
	logic [15:0] rxres_q;
	logic [3:0] rxerr_q;
	logic dtr_q, rts_q;
	logic [3:0] delta_q, delta_d;
	logic [7:0] fc_q;
	logic [1:0] area_q;
	logic [15:0] rdata_q;
	logic go_q;
	logic [8:0] len_q;
	spsmc_lines_t s1_q, s2_q, prev_q;

	spsmc_mode_t mode;
	logic [1:0] hs;
	logic present, configured;
	assign mode = spsmc_mode_t'(ctrl_q[SPSMC_CTRL_MODE +: 3]);
	assign hs = ctrl_q[SPSMC_CTRL_HS +: 2];
	assign configured = ctrl_q[SPSMC_CTRL_CFG];
	assign present = ctrl_q[SPSMC_CTRL_PRESENT];

	// Decoded strobes.
	wire wr_ctrl = bus.wr && bus.addr == SPSMC_A_CTRL;
	wire wr_send = bus.wr && bus.addr == SPSMC_A_SEND;
	wire wr_modem = bus.wr && bus.addr == SPSMC_A_MODEM;
	wire rd_mstat = bus.rd && bus.addr == SPSMC_A_MSTAT;
	wire [8:0] req_len = bus.wdata[8:0];
	wire req_bad = bus.wdata[SPSMC_SEND_BAD];
	wire req_full = bus.wdata[SPSMC_SEND_FULL];

	// Length limits depend on the framing mode.
	wire long_checked = mode != SPSMC_RAW;
	wire two_min = mode == SPSMC_DRIVE || mode == SPSMC_MB_MASTER;
	wire too_long = long_checked && req_len > SPSMC_MAX_LEN;
	wire too_short = mode != SPSMC_MB_SLAVE && (two_min ? req_len < SPSMC_MIN2 : req_len == 9'h000);
	wire is_empty = req_len == 9'h000;

	// ==========================================================
	// Send request screening; a rejected request never reaches the line.
	logic accept;
	always_comb
	begin
		result_d = result_q;
		accept = 1'b0;
		if (wr_send)
		begin
			if (!present)
				result_d = SPSMC_RC_NO_IF;
			else if (!configured)
				result_d = SPSMC_RC_NO_CFG;
			else if (too_long)
				result_d = SPSMC_RC_LONG;
			else if (is_empty && mode == SPSMC_RAW)
				result_d = SPSMC_RC_EMPTY;
			else if (too_short)
				result_d = SPSMC_RC_SHORT;
			else if (mode == SPSMC_FRAMED && req_bad)
				result_d = SPSMC_RC_BADCH;
			else if (req_full && mode != SPSMC_MB_SLAVE)
				result_d = SPSMC_RC_OVFL;
			else
			begin
				result_d = SPSMC_RC_BUFFERED;
				accept = 1'b1;
			end
		end
		else
		begin
			unique case (ev_code)
				SPSMC_EV_NONE: result_d = result_q;
				SPSMC_EV_BUF: result_d = SPSMC_RC_BUFFERED;
				SPSMC_EV_LINE: result_d = SPSMC_RC_ACTIVE;
				SPSMC_EV_DONE: result_d = (mode == SPSMC_RAW || mode == SPSMC_FRAMED
					|| mode == SPSMC_MB_SLAVE) ? SPSMC_RC_DONE : SPSMC_RC_OK;
				SPSMC_EV_NAK: result_d = SPSMC_RC_NAK;
				SPSMC_EV_NOACK: result_d = SPSMC_RC_NOACK;
				SPSMC_EV_NOSPACE: result_d = SPSMC_RC_NOSPACE;
				SPSMC_EV_TMO: result_d = SPSMC_RC_TMO;
				SPSMC_EV_CSUM: result_d = SPSMC_RC_CSUM;
				SPSMC_EV_ADDR: result_d = SPSMC_RC_NAK;
				SPSMC_EV_RLONG: result_d = SPSMC_RC_RLONG;
				SPSMC_EV_BADFC: result_d = SPSMC_RC_NOACK;
				SPSMC_EV_DIAG_OK: result_d = {SPSMC_HI_OK, ev_diag};
				SPSMC_EV_DIAG_ERR: result_d = {SPSMC_HI_ERR, ev_diag};
				SPSMC_EV_DIAG_NOEX: result_d = {SPSMC_HI_NOEX, ev_diag};
				SPSMC_EV_OK_ERR: result_d = SPSMC_RC_OK_ERR;
			endcase
		end
	end

	// Result word and the send hand-off to the line engine.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			result_q <= SPSMC_RC_DONE;
			go_q <= 1'b0;
			len_q <= 9'h000;
		end
		else
		begin
			result_q <= result_d;
			go_q <= accept;
			if (accept)
				len_q <= req_len;
		end
	end

	// ==========================================================
	// Receive side status, captured when the engine completes a frame.
	wire rx_done = ev_code == SPSMC_EV_DONE;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxlen_q <= 9'h000;
			rxres_q <= SPSMC_RC_DONE;
			rxerr_q <= 4'h0;
		end
		else if (rx_done)
		begin
			rxlen_q <= (mode == SPSMC_RAW || rx_user_ok) ? rx_count : 9'h000;
			rxres_q <= rx_area_small ? SPSMC_RC_EMPTY : SPSMC_RC_DONE;
			rxerr_q <= (mode == SPSMC_RAW) ? {rx_line_err, 1'b0} : 4'h0;
		end
	end

	// ==========================================================
	// Modem lines: inputs pass two flops before any logic.
	wire spsmc_lines_t changed = spsmc_lines_t'(s2_q ^ prev_q);
	// Clear on read; a new change wins
	assign delta_d = (rd_mstat ? 4'h0 : delta_q) | changed;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			prev_q <= '0;
			delta_q <= 4'h0;
		end
		else
		begin
			s1_q <= lines_in;
			s2_q <= s1_q;
			prev_q <= s2_q;
			delta_q <= delta_d;
		end
	end

	// Output line writes honour mask and handshake setting.
	wire line_wr_ok = wr_modem && hs == 2'h0;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			dtr_q <= 1'b0;
			rts_q <= 1'b0;
			ctrl_q <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= bus.wdata[7:0];
			if (line_wr_ok && bus.wdata[SPSMC_MW_MASK + SPSMC_MW_DTR])
				dtr_q <= bus.wdata[SPSMC_MW_DTR];
			if (line_wr_ok && bus.wdata[SPSMC_MW_MASK + SPSMC_MW_RTS])
				rts_q <= bus.wdata[SPSMC_MW_RTS];
		end
	end

	// ==========================================================
	// Slave function code answer and area selection.
	logic [1:0] area_d;
	always_comb
	begin
		unique case (mb_fc)
			8'h01, 8'h05: area_d = 2'h0;
			8'h02: area_d = 2'h1;
			8'h04: area_d = 2'h2;
			default: area_d = 2'h3;
		endcase
	end
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			fc_q <= 8'h00;
			area_q <= 2'h0;
		end
		else if (mb_fc_valid)
		begin
			fc_q <= mb_fail ? (mb_fc | SPSMC_FC_ERR) : mb_fc;
			area_q <= area_d;
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses read zero.
	// Status byte layout
	wire [7:0] mstat = {2'b00, rts_q, dtr_q, s2_q.cd, s2_q.ri, s2_q.dsr, s2_q.cts};
	logic [15:0] rmux;
	always_comb
	begin
		unique case (bus.addr)
			SPSMC_A_CTRL: rmux = {8'h00, ctrl_q};
			SPSMC_A_RESULT: rmux = result_q;
			SPSMC_A_RXLEN: rmux = {7'h00, rxlen_q};
			SPSMC_A_RXERR: rmux = {12'h000, rxerr_q};
			SPSMC_A_EVENT: rmux = rxres_q;
			SPSMC_A_MSTAT: rmux = {4'h0, delta_q, mstat};
			SPSMC_A_MBFC: rmux = {6'h00, area_q, fc_q};
			default: rmux = 16'h0000;
		endcase
	end
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rdata_q <= 16'h0000;
		else
			rdata_q <= bus.rd ? rmux : 16'h0000;
	end

	assign rdata = rdata_q;
	assign dtr = dtr_q;
	assign rts = rts_q;
	assign send_go = go_q;
	assign send_len = len_q;
	assign mb_area = area_q;

	// ==========================================================
	// Assertions
	property p_empty;
		@(posedge mclk) disable iff (!resetn)
		wr_send && present && configured && mode == SPSMC_RAW && req_len == 9'h000
		|=> result_q == SPSMC_RC_EMPTY && !send_go;
	endproperty
	a_empty: assert property (p_empty) else $error("empty send code wrong");

	property p_long;
		@(posedge mclk) disable iff (!resetn)
		wr_send && present && configured && mode != SPSMC_RAW && req_len > SPSMC_MAX_LEN
		|=> result_q == SPSMC_RC_LONG && !send_go;
	endproperty
	a_long: assert property (p_long) else $error("long send not rejected");

	property p_noif;
		@(posedge mclk) disable iff (!resetn)
		wr_send && !present |=> result_q == SPSMC_RC_NO_IF;
	endproperty
	a_noif: assert property (p_noif) else $error("missing interface code wrong");

	property p_accept;
		@(posedge mclk) disable iff (!resetn)
		send_go |-> result_q == SPSMC_RC_BUFFERED;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted send not busy");

	property p_hs_block;
		@(posedge mclk) disable iff (!resetn)
		wr_modem && hs != 2'h0 |=> $stable(dtr) && $stable(rts);
	endproperty
	a_hs_block: assert property (p_hs_block) else $error("line written under handshake");

	property p_mask;
		@(posedge mclk) disable iff (!resetn)
		wr_modem && !bus.wdata[SPSMC_MW_MASK + SPSMC_MW_DTR] |=> $stable(dtr);
	endproperty
	a_mask: assert property (p_mask) else $error("unmasked line changed");

	property p_delta_clr;
		@(posedge mclk) disable iff (!resetn)
		rd_mstat && changed == 4'h0 |=> delta_q == 4'h0;
	endproperty
	a_delta_clr: assert property (p_delta_clr) else $error("change flags not cleared");

	property p_delta_set;
		@(posedge mclk) disable iff (!resetn)
		s2_q.cts != prev_q.cts |=> delta_q[0];
	endproperty
	a_delta_set: assert property (p_delta_set) else $error("change not flagged");

	property p_fc_err;
		@(posedge mclk) disable iff (!resetn)
		mb_fc_valid && mb_fail |=> fc_q[7];
	endproperty
	a_fc_err: assert property (p_fc_err) else $error("error answer flag missing");

	c_go: cover property (@(posedge mclk) disable iff (!resetn) send_go);
	c_nak: cover property (@(posedge mclk) disable iff (!resetn) result_q == SPSMC_RC_NAK);
	c_delta: cover property (@(posedge mclk) disable iff (!resetn) rd_mstat && delta_q != 4'h0);
endmodule

// ===== verification/spsmc_partner.sv
// Model of the line engine and modem pins facing the status block.
`timescale 1ns/10ps
module spsmc_partner
(
	input wire logic mclk,
	output logic [3:0] ev_code,
	output logic [7:0] ev_diag,
	output logic [8:0] rx_count,
	output logic rx_user_ok,
	output logic rx_area_small,
	output logic [2:0] rx_line_err,
	output spsmc_pkg::spsmc_lines_t lines_in,
	output logic [7:0] mb_fc,
	output logic mb_fail,
	output logic mb_fc_valid
);
	import spsmc_pkg::*;
	// ==========================================================
	// Idle state at time zero.
	initial
	begin
		ev_code = SPSMC_EV_NONE;
		ev_diag = 8'h00;
		rx_count = 9'h000;
		rx_user_ok = 1'b0;
		rx_area_small = 1'b0;
		rx_line_err = 3'h0;
		lines_in = '0;
		mb_fc = 8'h00;
		mb_fail = 1'b0;
		mb_fc_valid = 1'b0;
	end
	// ==========================================================
	// Receive details, held until the next call.
	task automatic setrx(input logic [8:0] n, input logic ok, input logic sm, input logic [2:0] e);
		@(posedge mclk);
		rx_count <= n;
		rx_user_ok <= ok;
		rx_area_small <= sm;
		rx_line_err <= e;
	endtask
	// One-cycle event; the stale diagnostic byte is scrambled so nothing can lean on it.
	task automatic post(input logic [3:0] c, input logic [7:0] d);
		@(posedge mclk);
		ev_code <= c;
		ev_diag <= d;
		@(posedge mclk);
		ev_code <= SPSMC_EV_NONE;
		ev_diag <= ~d;
	endtask
	// Slave answer pulse; the code lines change once the pulse is gone.
	task automatic answer(input logic [7:0] fc, input logic f);
		@(posedge mclk);
		mb_fc <= fc;
		mb_fail <= f;
		mb_fc_valid <= 1'b1;
		@(posedge mclk);
		mb_fc_valid <= 1'b0;
		mb_fc <= ~fc;
		mb_fail <= ~f;
	endtask
	// Modem input pins change on a clock edge, in step with the block.
	task automatic pins(input logic [3:0] v);
		@(posedge mclk);
		lines_in <= v;
	endtask
endmodule

// ===== verification/testbench.sv
// Self-checking testbench for the serial port status block.
`timescale 1ns/10ps
module testbench;
	import spsmc_pkg::*;
	logic mclk;
	logic resetn;
	spsmc_bus_t bus;
	logic [15:0] rdata;
	logic [3:0] ev_code;
	logic [7:0] ev_diag;
	logic [8:0] rx_count;
	logic rx_user_ok;
	logic rx_area_small;
	logic [2:0] rx_line_err;
	spsmc_lines_t lines_in;
	logic [7:0] mb_fc;
	logic mb_fail;
	logic mb_fc_valid;
	logic dtr;
	logic rts;
	logic send_go;
	logic [8:0] send_len;
	logic [1:0] mb_area;
	int n_errors;
	int compares;
	logic [3:0] evs [11];
	logic [15:0] exps [11];
	logic [7:0] fcs [7];
	logic [1:0] areas [7];

	spsmc_top dut (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .ev_code(ev_code),
		.ev_diag(ev_diag), .rx_count(rx_count), .rx_user_ok(rx_user_ok),
		.rx_area_small(rx_area_small), .rx_line_err(rx_line_err), .lines_in(lines_in),
		.mb_fc(mb_fc), .mb_fail(mb_fail), .mb_fc_valid(mb_fc_valid), .dtr(dtr), .rts(rts),
		.send_go(send_go), .send_len(send_len), .mb_area(mb_area));
	spsmc_partner peer (.mclk(mclk), .ev_code(ev_code), .ev_diag(ev_diag), .rx_count(rx_count),
		.rx_user_ok(rx_user_ok), .rx_area_small(rx_area_small), .rx_line_err(rx_line_err),
		.lines_in(lines_in), .mb_fc(mb_fc), .mb_fail(mb_fail), .mb_fc_valid(mb_fc_valid));

	// ==========================================================
	// Clock at 125 MHz.
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ==========================================================
	// Comparison, bus cycles and the closing report.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
		// Let the edge that takes the write settle before anyone looks at outputs.
		#1;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic cfg(input logic [2:0] m, input logic [1:0] hs);
		wr(SPSMC_A_CTRL, {8'h00, 2'b11, hs, 1'b0, m});
	endtask
	task automatic snd(input logic [15:0] d, input logic go, input logic [15:0] e);
		wr(SPSMC_A_SEND, d);
		#1;
		chk({15'h0000, send_go}, {15'h0000, go});
		if (go)
			chk({7'h00, send_len}, {7'h00, d[8:0]});
		rd(SPSMC_A_RESULT, e);
	endtask
	task automatic ev(input logic [3:0] c, input logic [15:0] e);
		peer.post(c, 8'h5A);
		rd(SPSMC_A_RESULT, e);
	endtask
	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// A hang counts as a mismatch and ends the run.
	initial
	begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		test_done();
	end
	// ==========================================================
	// Main sequence.
	initial
	begin
		n_errors = 0;
		compares = 0;
		resetn = 1'b0;
		bus = '0;
		evs = '{SPSMC_EV_NOSPACE, SPSMC_EV_TMO, SPSMC_EV_CSUM, SPSMC_EV_RLONG, SPSMC_EV_BADFC,
			SPSMC_EV_ADDR, SPSMC_EV_OK_ERR, SPSMC_EV_DONE, SPSMC_EV_DIAG_OK, SPSMC_EV_DIAG_ERR,
			SPSMC_EV_DIAG_NOEX};
		exps = '{16'h8080, 16'h8090, 16'h80F0, 16'h80FD, 16'h80FE, 16'h80FF, 16'h2001, 16'h2000,
			16'h205A, 16'h805A, 16'h905A};
		fcs = '{8'h01, 8'h05, 8'h02, 8'h04, 8'h03, 8'h06, 8'h10};
		areas = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd(SPSMC_A_RESULT, 16'h0000);
		cfg(3'h0, 2'h0);
		snd(16'h0000, 1'b0, 16'h1000);
		snd(16'h0005, 1'b1, 16'h7001);
		ev(SPSMC_EV_LINE, 16'h7002);
		ev(SPSMC_EV_BUF, 16'h7001);
		peer.setrx(9'h007, 1'b0, 1'b1, 3'h7);
		ev(SPSMC_EV_DONE, 16'h0000);
		rd(SPSMC_A_EVENT, 16'h1000);
		rd(SPSMC_A_RXLEN, 16'h0007);
		rd(SPSMC_A_RXERR, 16'h000E);
		$display("Test raw finished");
		wr(SPSMC_A_CTRL, 16'h0000);
		snd(16'h0005, 1'b0, 16'h809A);
		wr(SPSMC_A_CTRL, 16'h0080);
		snd(16'h0005, 1'b0, 16'h809B);
		cfg(3'h1, 2'h0);
		snd(16'h0101, 1'b0, 16'h9001);
		snd(16'h0100, 1'b1, 16'h7001);
		snd(16'h0205, 1'b0, 16'h9004);
		snd(16'h0405, 1'b0, 16'h9000);
		snd(16'h0000, 1'b0, 16'h9002);
		peer.setrx(9'h009, 1'b0, 1'b0, 3'h0);
		ev(SPSMC_EV_DONE, 16'h0000);
		rd(SPSMC_A_RXLEN, 16'h0000);
		peer.setrx(9'h009, 1'b1, 1'b0, 3'h0);
		ev(SPSMC_EV_DONE, 16'h0000);
		rd(SPSMC_A_RXLEN, 16'h0009);
		rd(SPSMC_A_EVENT, 16'h0000);
		$display("Test framed finished");
		cfg(3'h3, 2'h0);
		snd(16'h0001, 1'b0, 16'h9002);
		snd(16'h0002, 1'b1, 16'h7001);
		cfg(3'h2, 2'h0);
		snd(16'h0000, 1'b0, 16'h9002);
		ev(SPSMC_EV_DONE, 16'h2000);
		ev(SPSMC_EV_NAK, 16'h80FF);
		ev(SPSMC_EV_NOACK, 16'h80FE);
		cfg(3'h4, 2'h0);
		for (int i = 0; i < 11; i++)
			ev(evs[i], exps[i]);
		$display("Test protocol codes finished");
		cfg(3'h5, 2'h0);
		snd(16'h0101, 1'b0, 16'h9001);
		for (int i = 0; i < 7; i++)
		begin
			peer.answer(fcs[i], 1'b0);
			rd(SPSMC_A_MBFC, {6'h00, areas[i], fcs[i]});
			chk({14'h0000, mb_area}, {14'h0000, areas[i]});
		end
		peer.answer(8'h03, 1'b1);
		rd(SPSMC_A_MBFC, {6'h00, 2'h3, 8'h83});
		$display("Test slave finished");
		cfg(3'h0, 2'h0);
		wr(SPSMC_A_MODEM, 16'h0301);
		chk({14'h0000, rts, dtr}, 16'h0001);
		wr(SPSMC_A_MODEM, 16'h0202);
		chk({14'h0000, rts, dtr}, 16'h0003);
		cfg(3'h0, 2'h1);
		wr(SPSMC_A_MODEM, 16'h0300);
		chk({14'h0000, rts, dtr}, 16'h0003);
		cfg(3'h0, 2'h0);
		peer.pins(4'h5);
		repeat (4) @(posedge mclk);
		rd(SPSMC_A_MSTAT, 16'h0535);
		rd(SPSMC_A_MSTAT, 16'h0035);
		$display("Test modem finished");
		test_done();
	end
endmodule
